// *** rtl/sac_consts.svh ***
// Function
// - a falling edge on the active-low start input begins a conversion
// - start edges during a conversion are ignored; no restart before completion
// - busy output is low for the whole conversion, high otherwise
// - the 14 result bits are decided one at a time, msb first
// - at conversion end the approximation word is loaded into the output latches
// - result bit 13 is the msb, bit 0 the lsb, on parallel outputs
// - flag high with msb low means input above the selected range
// - both range inputs high 0dB, 1/0 -3dB, 0/1 -6dB, both low -9dB
// - nap low powers down conversion circuitry, reference keeps running
// - sleep low shuts down essentially everything
// - flag high on most negative code or input 64 lsb over top
// - result is two's complement, zero at the negative input voltage
// - outputs update about 7ns after busy rises, never on that edge
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_CLK_MHZ 250
`define SAC_RES_BITS 14
`define SAC_CONV_NS 250
`define SAC_CONV_CYC ((`SAC_CONV_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_BIT_CYC (`SAC_CONV_CYC / `SAC_RES_BITS)
`define SAC_DATA_NS 7
`define SAC_DATA_CYC ((`SAC_DATA_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_ACQ_NS 100
`define SAC_ACQ_CYC ((`SAC_ACQ_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_NAP_WAKE_NS 250
`define SAC_NAP_WAKE_CYC ((`SAC_NAP_WAKE_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_SLEEP_WAKE_MS 210
`define SAC_SLEEP_WAKE_CYC (`SAC_SLEEP_WAKE_MS * `SAC_CLK_MHZ * 1000)

`define SAC_ADDR_STATUS 8'h00
`define SAC_ADDR_MASK 8'h04
`define SAC_ADDR_RESULT 8'h08
`define SAC_ADDR_CTRL 8'h0c

`define SAC_EV_DONE 0
`define SAC_EV_IGNORED 1
`define SAC_EV_RANGE 2
`define SAC_EV_BITS 3

`define SAC_CTRL_RST 1'b1
`define SAC_MOST_NEG 14'h2000

`endif

// *** rtl/sac_pkg.sv ***
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_SPAN_0DB,
    SAC_SPAN_3DB,
    SAC_SPAN_6DB,
    SAC_SPAN_9DB
  } sac_span_e;

  typedef enum {
    SAC_IDLE,
    SAC_CONV,
    SAC_LATCH
  } sac_state_e;
endpackage

// *** rtl/sac_sar_core.sv ***
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_sar_core
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sequencing
  input wire logic start_i,
  input wire logic step_i,
  input wire logic cmp_i,
  // trial word and end of the bit walk
  output logic [`SAC_RES_BITS-1:0] trial_o,
  output logic done_o
);
  localparam int NB = `SAC_RES_BITS;

  logic [NB-1:0] ptr_q;
  logic [NB:0] ptr_ext;

  assign ptr_ext = {1'b0, ptr_q};

  // one-hot pointer walks from the msb down to the lsb
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ptr_q <= '0;
    end else if (start_i) begin
      ptr_q <= {1'b1, {(NB-1){1'b0}}};
    end else if (step_i) begin
      ptr_q <= ptr_q >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= step_i & ptr_q[0];
    end
  end

  // the comparator keeps or drops the bit under trial, then the next one is tried
  for (genvar i = 0; i < NB; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        trial_o[i] <= 1'b0;
      end else if (start_i) begin
        trial_o[i] <= (i == NB - 1);
      end else if (step_i && ptr_q[i]) begin
        trial_o[i] <= cmp_i;
      end else if (step_i && ptr_ext[i+1]) begin
        trial_o[i] <= 1'b1;
      end
    end
  end
endmodule

// *** rtl/sac_conv_ctrl.sv ***
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int SLEEP_WAKE_CYC = `SAC_SLEEP_WAKE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host pins
  input wire logic conv_start_n_i,
  input wire logic nap_n_i,
  input wire logic deep_shutdown_n_i,
  input wire logic range_sel_0_i,
  input wire logic range_sel_1_i,
  output logic busy_n_o,
  output logic [`SAC_RES_BITS-1:0] result_o,
  output logic out_of_range_flag_o,
  // analog side
  input wire logic cmp_i,
  input wire logic over_top_i,
  output logic [`SAC_RES_BITS-1:0] dac_code_o,
  output logic track_o,
  output logic conv_pwr_en_o,
  output logic ref_pwr_en_o,
  output sac_span_e span_o,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic irq_o
);
  localparam int NB = `SAC_RES_BITS;
  localparam int EVB = `SAC_EV_BITS;
  localparam logic [3:0] BIT_LAST = 4'(`SAC_BIT_CYC - 1);
  localparam logic [3:0] DATA_LAST = 4'(`SAC_DATA_CYC - 1);
  localparam logic [25:0] NAP_WAKE = 26'(`SAC_NAP_WAKE_CYC);
  localparam logic [25:0] SLEEP_WAKE = 26'(SLEEP_WAKE_CYC);

  sac_state_e state_q;
  logic start_prev_q;
  logic start_fall;
  logic [3:0] tick_q;
  logic step;
  logic sar_start;
  logic sar_done;
  logic [NB-1:0] trial;
  logic [NB-1:0] word_q;
  logic range_q;
  logic [25:0] wake_q;
  logic awake;
  logic nap_prev_q;
  logic sleep_prev_q;
  logic powered;
  logic [EVB-1:0] status_q;
  logic [EVB-1:0] mask_q;
  logic [EVB-1:0] ev_set;
  logic [EVB-1:0] ev_clr;
  logic enable_q;
  logic wr_status;

  assign start_fall = start_prev_q & ~conv_start_n_i;
  assign powered = nap_n_i & deep_shutdown_n_i;
  // the release cycle itself is not awake yet: the wake timer loads one edge later
  assign awake = powered && nap_prev_q && sleep_prev_q && (wake_q == '0);
  assign sar_start = (state_q == SAC_IDLE) && start_fall && awake && enable_q;
  assign step = (state_q == SAC_CONV) && (tick_q == BIT_LAST);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_prev_q <= 1'b1;
      nap_prev_q <= 1'b1;
      sleep_prev_q <= 1'b1;
    end else begin
      start_prev_q <= conv_start_n_i;
      nap_prev_q <= nap_n_i;
      sleep_prev_q <= deep_shutdown_n_i;
    end
  end

  // power control: nap keeps the reference, sleep drops everything
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      conv_pwr_en_o <= 1'b0;
      ref_pwr_en_o <= 1'b0;
    end else begin
      conv_pwr_en_o <= powered;
      ref_pwr_en_o <= deep_shutdown_n_i;
    end
  end

  // wake timer; starts before it runs out are refused rather than converted badly
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_q <= '0;
    end else if (!powered) begin
      wake_q <= '0;
    end else if (!sleep_prev_q) begin
      wake_q <= SLEEP_WAKE;
    end else if (!nap_prev_q) begin
      wake_q <= NAP_WAKE;
    end else if (wake_q != '0) begin
      wake_q <= wake_q - 26'h0000001;
    end
  end

  // conversion sequencer; a power-down mid conversion aborts without latching
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= SAC_IDLE;
      tick_q <= '0;
    end else begin
      case (state_q)
        SAC_IDLE: begin
          tick_q <= '0;
          if (sar_start) begin
            state_q <= SAC_CONV;
          end
        end
        SAC_CONV: begin
          if (!powered) begin
            state_q <= SAC_IDLE;
          end else if (sar_done) begin
            state_q <= SAC_LATCH;
            tick_q <= '0;
          end else if (step) begin
            tick_q <= '0;
          end else begin
            tick_q <= tick_q + 4'h1;
          end
        end
        SAC_LATCH: begin
          if (tick_q == DATA_LAST) begin
            state_q <= SAC_IDLE;
            tick_q <= '0;
          end else begin
            tick_q <= tick_q + 4'h1;
          end
        end
        default: begin
          state_q <= SAC_IDLE;
        end
      endcase
    end
  end

  sac_sar_core u_sar (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(sar_start),
    .step_i(step),
    .cmp_i(cmp_i),
    .trial_o(trial),
    .done_o(sar_done)
  );

  assign dac_code_o = trial;

  // busy spans the whole bit walk only; further start edges only set the ignored-start event
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_n_o <= 1'b1;
      track_o <= 1'b1;
    end else begin
      busy_n_o <= ~(sar_start || ((state_q == SAC_CONV) && !sar_done && powered));
      track_o <= ~(sar_start || ((state_q == SAC_CONV) && !sar_done && powered));
    end
  end

  // finished word is held here until the delayed output update
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      word_q <= '0;
      range_q <= 1'b0;
    end else if (sar_done) begin
      word_q <= {~trial[NB-1], trial[NB-2:0]};
      range_q <= over_top_i || ({~trial[NB-1], trial[NB-2:0]} == `SAC_MOST_NEG);
    end
  end

  // output latches move only at the end of the delay after busy rises
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_o <= '0;
      out_of_range_flag_o <= 1'b0;
    end else if ((state_q == SAC_LATCH) && (tick_q == DATA_LAST)) begin
      result_o <= word_q;
      out_of_range_flag_o <= range_q;
    end
  end // otherwise held

  // span decode; a span change needs long analog settling, not tracked here
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      span_o <= SAC_SPAN_0DB;
    end else begin
      case ({range_sel_0_i, range_sel_1_i})
        2'b11: span_o <= SAC_SPAN_0DB;
        2'b10: span_o <= SAC_SPAN_3DB;
        2'b01: span_o <= SAC_SPAN_6DB;
        default: span_o <= SAC_SPAN_9DB;
      endcase
    end
  end

  // events: done, refused start, out of range
  assign ev_set[`SAC_EV_DONE] = (state_q == SAC_LATCH) && (tick_q == DATA_LAST);
  assign ev_set[`SAC_EV_IGNORED] = start_fall && !sar_start;
  assign ev_set[`SAC_EV_RANGE] = (state_q == SAC_LATCH) && (tick_q == DATA_LAST) && range_q;
  assign wr_status = wr_i && (addr_i == `SAC_ADDR_STATUS);
  assign ev_clr = wr_status ? wr_data_i[EVB-1:0] : '0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= '0;
      enable_q <= `SAC_CTRL_RST;
    end else if (wr_i && (addr_i == `SAC_ADDR_MASK)) begin
      mask_q <= wr_data_i[EVB-1:0];
    end else if (wr_i && (addr_i == `SAC_ADDR_CTRL)) begin
      enable_q <= wr_data_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (!rd_i) begin
      rd_data_o <= '0;
    end else if (addr_i == `SAC_ADDR_STATUS) begin
      rd_data_o <= {29'h0, status_q};
    end else if (addr_i == `SAC_ADDR_MASK) begin
      rd_data_o <= {29'h0, mask_q};
    end else if (addr_i == `SAC_ADDR_RESULT) begin
      rd_data_o <= {17'h0, out_of_range_flag_o, result_o};
    end else if (addr_i == `SAC_ADDR_CTRL) begin
      rd_data_o <= {29'h0, awake, ~busy_n_o, enable_q};
    end else begin
      rd_data_o <= '0;
    end
  end
endmodule

// *** bench/sac_conv_ctrl_assertions.sv ***
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_conv_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host pins
  input wire logic conv_start_n_i,
  input wire logic nap_n_i,
  input wire logic deep_shutdown_n_i,
  input wire logic busy_n_o,
  input wire logic [`SAC_RES_BITS-1:0] result_o,
  input wire logic out_of_range_flag_o,
  // analog side
  input wire logic track_o,
  input wire logic conv_pwr_en_o,
  input wire logic ref_pwr_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // a restart would stretch busy past one conversion
  logic [6:0] low_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || busy_n_o) begin
      low_q <= 7'h00;
    end else begin
      low_q <= low_q + 7'h01;
    end
  end
  sequence s_begin;
    $fell(busy_n_o);
  endsequence
  property p_start;
    s_begin |-> !$past(conv_start_n_i) && $past(conv_start_n_i, 2);
  endproperty
  property p_len;
    $rose(busy_n_o) && conv_pwr_en_o |-> low_q == 7'h39;
  endproperty
  property p_norestart;
    low_q <= 7'h39;
  endproperty
  property p_track;
    track_o == busy_n_o;
  endproperty
  property p_res;
    $changed(result_o) |-> $past(busy_n_o, 2) && !$past(busy_n_o, 3);
  endproperty
  property p_flag;
    $changed(out_of_range_flag_o) |-> $past(busy_n_o, 2) && !$past(busy_n_o, 3);
  endproperty
  property p_nap;
    !nap_n_i && deep_shutdown_n_i |=> !conv_pwr_en_o && ref_pwr_en_o;
  endproperty
  property p_sleep;
    !deep_shutdown_n_i |=> !conv_pwr_en_o && !ref_pwr_en_o;
  endproperty
  a_start: assert property (p_start)
    else $error("busy fell with no start edge");
  a_len: assert property (p_len)
    else $error("busy low length wrong");
  a_norestart: assert property (p_norestart)
    else $error("conversion restarted");
  a_track: assert property (p_track)
    else $error("track differs from busy");
  a_res: assert property (p_res)
    else $error("result moved off schedule");
  a_flag: assert property (p_flag)
    else $error("flag moved off schedule");
  a_nap: assert property (p_nap)
    else $error("nap power wrong");
  a_sleep: assert property (p_sleep)
    else $error("sleep power wrong");
endmodule

bind sac_conv_ctrl sac_conv_chk u_chk (
  .clk_i, .sys_rst_i, .conv_start_n_i, .nap_n_i, .deep_shutdown_n_i, .busy_n_o,
  .result_o, .out_of_range_flag_o, .track_o, .conv_pwr_en_o, .ref_pwr_en_o
);

// *** bench/sac_analog_model.sv ***
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_analog_model (
  // bench side
  input wire logic [`SAC_RES_BITS-1:0] vin_i,
  input wire logic over_i,
  // converter side
  input wire logic [`SAC_RES_BITS-1:0] dac_code_i,
  output logic cmp_o,
  output logic over_top_o
);
  // vin is offset binary like the dac, so mid scale sits at the negative input
  assign cmp_o = (vin_i >= dac_code_i);
  assign over_top_o = over_i;
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`include "sac_consts.svh"
module testbench
  import sac_pkg::*;
;
  logic clk_i, sys_rst_i, start_n, nap_n, slp_n, sel0, sel1, over, wr, rd, cmp, ovt;
  logic busy_n, flag, track, cpe, rpe, irq;
  logic [7:0] addr;
  logic [31:0] wd, rdata;
  logic [13:0] vin, dac, res;
  sac_span_e span;
  int num_errors, checks;
  sac_conv_ctrl #(.SLEEP_WAKE_CYC(20)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .conv_start_n_i(start_n), .nap_n_i(nap_n),
    .deep_shutdown_n_i(slp_n), .range_sel_0_i(sel0), .range_sel_1_i(sel1),
    .busy_n_o(busy_n), .result_o(res), .out_of_range_flag_o(flag), .cmp_i(cmp),
    .over_top_i(ovt), .dac_code_o(dac), .track_o(track), .conv_pwr_en_o(cpe),
    .ref_pwr_en_o(rpe), .span_o(span), .addr_i(addr), .wr_data_i(wd), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdata), .irq_o(irq)
  );
  sac_analog_model model (
    .vin_i(vin), .over_i(over), .dac_code_i(dac), .cmp_o(cmp), .over_top_o(ovt)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    chk(rdata, exp);
  endtask
  // extra start edges mid conversion must not change busy length or result
  task automatic conv(input logic [13:0] c, input logic ov);
    int n;
    vin <= c ^ 14'h2000;
    over <= ov;
    @(posedge clk_i);
    start_n <= 1'b0;
    n = 0;
    while (busy_n !== 1'b0 && n < 9) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (busy_n === 1'b0 && n < 99) begin
      @(posedge clk_i);
      n++;
      if (n == 5 || n == 12) start_n <= 1'b1;
      if (n == 8) start_n <= 1'b0;
    end
    chk(n, 32'd57);
    tick(3);
    chk({18'h0, res}, {18'h0, c});
    chk(flag, ov || c == `SAC_MOST_NEG);
    tick(26);
    $display("conversion %h done", c);
  endtask
  initial begin
    {start_n, nap_n, slp_n, sel0, sel1, over, wr, rd} = 8'hf8;
    addr = 8'h00;
    wd = 32'h0;
    vin = 14'h0000;
    num_errors = 0;
    checks = 0;
    sys_rst_i = 1'b1;
    tick(16);
    sys_rst_i <= 1'b0;
    tick(4);
    chk({res, flag}, 15'h0000);
    rd_reg(`SAC_ADDR_CTRL, 32'h5);
    for (int i = 0; i < 4; i++) begin
      sel0 <= ~i[1];
      sel1 <= ~i[0];
      tick(3);
      chk(span, 32'(i));
    end
    $display("span test done");
    conv(14'h0000, 1'b0);
    conv(14'h1fff, 1'b0);
    conv(14'h2000, 1'b0);
    conv(14'h3fff, 1'b0);
    conv(14'h1555, 1'b1);
    nap_n <= 1'b0;
    tick(3);
    chk({cpe, rpe}, 2'b01);
    start_n <= 1'b0;
    tick(4);
    chk(busy_n, 1'b1);
    start_n <= 1'b1;
    nap_n <= 1'b1;
    tick(70);
    slp_n <= 1'b0;
    tick(3);
    chk({cpe, rpe}, 2'b00);
    slp_n <= 1'b1;
    tick(30);
    $display("power test done");
    conv(14'h0abc, 1'b0);
    rd_reg(`SAC_ADDR_RESULT, 32'h0abc);
    rd_reg(`SAC_ADDR_STATUS, 32'h7);
    chk(irq, 1'b0);
    wr_reg(`SAC_ADDR_MASK, 32'h1);
    tick(3);
    chk(irq, 1'b1);
    wr_reg(`SAC_ADDR_STATUS, 32'h7);
    tick(3);
    chk(irq, 1'b0);
    rd_reg(`SAC_ADDR_STATUS, 32'h0);
    rd_reg(8'h10, 32'h0);
    wr_reg(`SAC_ADDR_CTRL, 32'h0);
    start_n <= 1'b0;
    tick(4);
    chk(busy_n, 1'b1);
    start_n <= 1'b1;
    rd_reg(`SAC_ADDR_STATUS, 32'h2);
    wr_reg(`SAC_ADDR_CTRL, 32'h1);
    rd_reg(`SAC_ADDR_CTRL, 32'h5);
    $display("register test done");
    report_and_stop();
  end
endmodule
